// *** logic/hims_device.sv ***
`timescale 1ns/1ps
`include "hims_defines.svh"

// ****************************************************************************
// PHY end of the host interconnect: picks serial path or management bus
// ****************************************************************************
module hims_device (
  // Core clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  // Link toward the MAC.
  hims_if.dev bus,
  // PHY status, core clock domain.
  input wire logic i_phy_power_down,
  input wire logic i_phy_idle,
  input wire logic i_link_disconnect,
  input wire logic i_low_power_idle,
  input wire hims_pkg::hims_smb_rate_e i_smb_rate,
  // Transmit toward the MAC, link clock domain.
  input wire hims_pkg::hims_beat_s i_tx,
  output logic o_tx_ready,
  output logic o_tx_drop,
  output logic o_msg_acked,
  // Receive from the MAC, link clock domain.
  output hims_pkg::hims_beat_s o_rx,
  output logic o_rx_drop,
  output logic o_stray_beat,
  // Path status, core clock domain.
  output logic o_smbus_active,
  output logic o_serial_power_down,
  output logic o_speed_10,
  output logic o_serial_electrical_idle
);

  // ****************************************************************************
  // State
  // ****************************************************************************
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] hl_sync;
    logic hl_prev;
    logic [`HIMS_STAT_W-1:0] st_s1;
    logic [`HIMS_STAT_W-1:0] st_s2;
    hims_pkg::hims_path_e path;
    hims_pkg::hims_tx_s tx;
    logic tx_rdy;
    logic rx_busy;
    hims_pkg::hims_beat_s ser_out;
    hims_pkg::hims_beat_s smb_out;
    hims_pkg::hims_beat_s rx;
    logic rx_drop;
    logic tx_drop;
    logic acked;
    logic stray;
    logic ei;
  } hims_dev_link_s;

  typedef struct packed {
    logic [1:0] smb_s;
    logic [1:0] ei_s;
    logic smb_active;
    logic ser_pd;
    logic spd10;
    logic ei;
  } hims_dev_core_s;

  hims_dev_link_s l_q;
  hims_dev_link_s l_d;
  hims_dev_core_s c_q;
  hims_dev_core_s c_d;

  // ****************************************************************************
  // Link clock domain
  // ****************************************************************************
  // Follows the host link reset, moves packets and messages on the chosen path.
  always_comb begin
    hims_pkg::hims_txo_s txo;
    hims_pkg::hims_rxo_s rxo;
    hims_pkg::hims_beat_s in_beat;
    hims_pkg::hims_beat_s other_beat;
    hims_pkg::hims_beat_s out_beat;
    hims_pkg::hims_pace_t plen;
    logic rise;
    logic fall;
    logic sw;
    logic ack_in;
    txo = '0;
    rxo = '0;
    in_beat = '0;
    other_beat = '0;
    out_beat = '0;
    plen = '0;
    rise = 1'b0;
    fall = 1'b0;
    sw = 1'b0;
    ack_in = 1'b0;
    l_d = l_q;
    // Two flip-flops before any logic reads a foreign signal.
    l_d.rst_sync = {l_q.rst_sync[0], i_reset};
    l_d.hl_sync = {l_q.hl_sync[0], bus.host_link_reset_n};
    l_d.hl_prev = l_q.hl_sync[1];
    l_d.st_s1 = {i_smb_rate, i_phy_power_down, i_phy_idle, i_link_disconnect, i_low_power_idle};
    l_d.st_s2 = l_q.st_s1;
    // One switch per synchronised edge of the host link reset.
    rise = l_q.hl_sync[1] && !l_q.hl_prev;
    fall = !l_q.hl_sync[1] && l_q.hl_prev;
    sw = (rise && (l_q.path == hims_pkg::HIMS_PATH_SMB)) || (fall && (l_q.path == hims_pkg::HIMS_PATH_SER));
    if (rise) begin
      l_d.path = hims_pkg::HIMS_PATH_SER;
    end else if (fall) begin
      l_d.path = hims_pkg::HIMS_PATH_SMB;
    end
    // Only the selected path feeds the receiver; the other is watched for strays.
    if (l_q.path == hims_pkg::HIMS_PATH_SER) begin
      in_beat = bus.h2d_ser;
      other_beat = bus.h2d_smb;
    end else begin
      in_beat = bus.h2d_smb;
      other_beat = bus.h2d_ser;
    end
    ack_in = bus.h2d_ser.ack || bus.h2d_smb.ack;
    plen = hims_pkg::hims_pace_len(l_d.path, hims_pkg::hims_smb_rate_e'(l_q.st_s2[5:4]));
    txo = hims_pkg::hims_tx_step(l_q.tx, i_tx, i_tx.valid && l_q.tx_rdy, sw, ack_in, 1'b1, plen);
    rxo = hims_pkg::hims_rx_step(l_q.rx_busy, in_beat, sw);
    l_d.tx = txo.st;
    l_d.tx_rdy = hims_pkg::hims_tx_rdy(txo.st, 1'b1);
    l_d.rx_busy = rxo.busy;
    l_d.rx = rxo.out;
    l_d.rx_drop = rxo.drop;
    l_d.tx_drop = txo.drop;
    l_d.acked = txo.done;
    l_d.stray = other_beat.valid && !sw;
    // Outgoing beat carries any acknowledge and goes only on the new path.
    out_beat = txo.out;
    out_beat.ack = rxo.ack;
    l_d.ser_out = (l_d.path == hims_pkg::HIMS_PATH_SER) ? out_beat : '0;
    l_d.smb_out = (l_d.path == hims_pkg::HIMS_PATH_SMB) ? out_beat : '0;
    l_d.smb_out.hs = sw;
    // Serial path rests in electrical idle when an idle cause is set and the PHY has nothing to carry.
    l_d.ei = (l_d.path == hims_pkg::HIMS_PATH_SER) && (|l_q.st_s2[3:0]) &&
             (l_d.tx.st == hims_pkg::HIMS_TX_IDLE) && !l_d.rx_busy;
    if (l_q.rst_sync[1]) begin
      l_d = '0;
      l_d.rst_sync = {l_q.rst_sync[0], i_reset};
    end
  end

  // Registers the link domain state.
  always_ff @(posedge bus.link_clk) begin
    l_q <= l_d;
  end

  // ****************************************************************************
  // Core clock domain
  // ****************************************************************************
  // Brings the path choice and idle level over to the core clock.
  always_comb begin
    c_d = c_q;
    c_d.smb_s = {c_q.smb_s[0], l_q.path == hims_pkg::HIMS_PATH_SMB};
    c_d.ei_s = {c_q.ei_s[0], l_q.ei};
    c_d.smb_active = c_q.smb_s[1];
    c_d.ser_pd = c_q.smb_s[1];
    c_d.spd10 = c_q.smb_s[1];
    c_d.ei = c_q.ei_s[1];
    if (i_reset) begin
      c_d = '0;
      c_d.smb_s = 2'h3;
      c_d.smb_active = 1'b1;
      c_d.ser_pd = 1'b1;
      c_d.spd10 = 1'b1;
    end
  end

  // Registers the core domain state.
  always_ff @(posedge i_clk) begin
    c_q <= c_d;
  end

  // ****************************************************************************
  // Outputs
  // ****************************************************************************
  // Every output is a state flip-flop.
  assign bus.d2h_ser = l_q.ser_out;
  assign bus.d2h_smb = l_q.smb_out;
  assign o_tx_ready = l_q.tx_rdy;
  assign o_tx_drop = l_q.tx_drop;
  assign o_msg_acked = l_q.acked;
  assign o_rx = l_q.rx;
  assign o_rx_drop = l_q.rx_drop;
  assign o_stray_beat = l_q.stray;
  assign o_smbus_active = c_q.smb_active;
  assign o_serial_power_down = c_q.ser_pd;
  assign o_speed_10 = c_q.spd10;
  assign o_serial_electrical_idle = c_q.ei;

endmodule

// *** logic/hims_defines.svh ***
`ifndef HIMS_DEFINES_SVH
`define HIMS_DEFINES_SVH

// ****************************************************************************
// Host interconnect mode switch constants
// ****************************************************************************
// How it works
// - Reset rising moves traffic to serial path.
// - Unfinished packets dropped at serial switch.
// - Unacknowledged bus message resent on serial.
// - Reset falling moves traffic to bus.
// - Unfinished packets dropped when reset falls.
// - Unacknowledged serial message resent on bus.
// - Path follows platform power state automatically.
// - Idle conditions put serial in electrical idle.
// - Sleep powers serial down, bus carries traffic.
// - Serial path runs one fixed rate.
// - Serial frames are whole Ethernet packets.
// - Bus runs at 100, 400, 1000 kHz.
// - Switch handshake travels over the bus.
// - Host configures and messages over the bus.
// - Serial carries data and management accesses.
// - Host side decides when to switch.
// - Link speed drops to 10 Mbps on bus.

// Core clock period and the divider that makes the link clock.
`define HIMS_CLK_PERIOD_NS 8
`define HIMS_LINK_DIV 4
`define HIMS_LINK_HALF 2
`define HIMS_LINK_CNT_W 2
`define HIMS_LINK_PERIOD_NS (`HIMS_CLK_PERIOD_NS * `HIMS_LINK_DIV)

// Serial path line rate in Mbps; one byte moves per link clock.
`define HIMS_SER_RATE_MBPS 1250

// Management bus rates and the byte time they give, in link cycles.
`define HIMS_SMB_KHZ_STD 100
`define HIMS_SMB_KHZ_FAST 400
`define HIMS_SMB_KHZ_PLUS 1000
`define HIMS_SMB_BITS_PER_BYTE 9
`define HIMS_SMB_BYTE_NS(khz) (`HIMS_SMB_BITS_PER_BYTE * 1000000 / (khz))
`define HIMS_SMB_CYC(khz) ((`HIMS_SMB_BYTE_NS(khz) + `HIMS_LINK_PERIOD_NS - 1) / `HIMS_LINK_PERIOD_NS)
`define HIMS_PACE_W 12

// In-band message store.
`define HIMS_MSG_MAX 8
`define HIMS_MSG_IW 3

// Status input vector width: four idle causes and the bus rate.
`define HIMS_STAT_W 6

`endif

// *** logic/hims_pkg.sv ***
package hims_pkg;
`include "hims_defines.svh"

  // ****************************************************************************
  // Types
  // ****************************************************************************
  typedef enum logic {HIMS_PATH_SMB, HIMS_PATH_SER} hims_path_e;
  typedef enum logic [1:0] {HIMS_SMB_STD, HIMS_SMB_FAST, HIMS_SMB_PLUS} hims_smb_rate_e;
  typedef enum logic [2:0] {
    HIMS_TX_IDLE, HIMS_TX_PKT, HIMS_TX_FLUSH, HIMS_TX_MLOAD, HIMS_TX_MSEND, HIMS_TX_MWAIT
  } hims_tx_e;
  typedef logic [`HIMS_PACE_W-1:0] hims_pace_t;
  typedef logic [`HIMS_MSG_IW-1:0] hims_idx_t;

  // One byte beat on either path, plus acknowledge and handshake flags.
  typedef struct packed {
    logic valid;
    logic last;
    logic msg;
    logic ack;
    logic hs;
    logic [7:0] data;
  } hims_beat_s;

  typedef struct packed {
    hims_tx_e st;
    hims_idx_t idx;
    hims_idx_t len;
    hims_pace_t pace;
    logic [`HIMS_MSG_MAX-1:0][7:0] mem;
  } hims_tx_s;

  typedef struct packed {
    hims_tx_s st;
    hims_beat_s out;
    logic drop;
    logic done;
  } hims_txo_s;

  typedef struct packed {
    logic busy;
    logic drop;
    logic ack;
    hims_beat_s out;
  } hims_rxo_s;

  // ****************************************************************************
  // Shared functions
  // ****************************************************************************
  // Link cycles between beats minus one; the serial path never waits.
  function automatic hims_pace_t hims_pace_len(hims_path_e p, hims_smb_rate_e r);
    hims_pace_t v;
    v = '0;
    if (p == HIMS_PATH_SMB) begin
      case (r)
        HIMS_SMB_FAST: v = hims_pace_t'(`HIMS_SMB_CYC(`HIMS_SMB_KHZ_FAST) - 1);
        HIMS_SMB_PLUS: v = hims_pace_t'(`HIMS_SMB_CYC(`HIMS_SMB_KHZ_PLUS) - 1);
        default: v = hims_pace_t'(`HIMS_SMB_CYC(`HIMS_SMB_KHZ_STD) - 1);
      endcase
    end
    return v;
  endfunction

  // Whether the sender takes a user beat in the cycle after this state.
  function automatic logic hims_tx_rdy(hims_tx_s s, logic gate);
    logic r;
    r = 1'b0;
    case (s.st)
      HIMS_TX_IDLE, HIMS_TX_PKT: r = (s.pace == '0) && gate;
      HIMS_TX_FLUSH, HIMS_TX_MLOAD: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Sender step: packets stream through, messages are stored for resending.
  function automatic hims_txo_s hims_tx_step(hims_tx_s s, hims_beat_s in, logic acc, logic sw, logic ack,
                                             logic gate, hims_pace_t plen);
    hims_txo_s o;
    o.st = s;
    o.out = '0;
    o.drop = 1'b0;
    o.done = 1'b0;
    if (s.pace != '0) begin
      o.st.pace = s.pace - hims_pace_t'(1);
    end
    case (s.st)
      HIMS_TX_IDLE: begin
        if (acc && in.msg) begin
          o.st.mem[0] = in.data;
          o.st.idx = in.last ? '0 : hims_idx_t'(1);
          o.st.len = '0;
          o.st.st = in.last ? HIMS_TX_MSEND : HIMS_TX_MLOAD;
        end else if (acc) begin
          o.out = in;
          o.out.ack = 1'b0;
          o.out.hs = 1'b0;
          o.st.pace = plen;
          o.st.st = in.last ? HIMS_TX_IDLE : HIMS_TX_PKT;
        end
      end
      HIMS_TX_PKT: begin
        if (acc) begin
          o.out = in;
          o.out.ack = 1'b0;
          o.out.hs = 1'b0;
          o.st.pace = plen;
          o.st.st = in.last ? HIMS_TX_IDLE : HIMS_TX_PKT;
        end
      end
      HIMS_TX_FLUSH: begin
        if (acc && in.last) begin
          o.st.st = HIMS_TX_IDLE;
        end
      end
      HIMS_TX_MLOAD: begin
        if (acc) begin
          o.st.mem[s.idx] = in.data;
          if (in.last) begin
            o.st.len = s.idx;
            o.st.idx = '0;
            o.st.st = HIMS_TX_MSEND;
          end else if (s.idx != hims_idx_t'(`HIMS_MSG_MAX - 1)) begin
            o.st.idx = s.idx + hims_idx_t'(1);
          end
        end
      end
      HIMS_TX_MSEND: begin
        if ((s.pace == '0) && gate) begin
          o.out.valid = 1'b1;
          o.out.msg = 1'b1;
          o.out.last = (s.idx == s.len);
          o.out.data = s.mem[s.idx];
          o.st.pace = plen;
          o.st.idx = s.idx + hims_idx_t'(1);
          o.st.st = (s.idx == s.len) ? HIMS_TX_MWAIT : HIMS_TX_MSEND;
        end
      end
      HIMS_TX_MWAIT: begin
        if (ack) begin
          o.st.st = HIMS_TX_IDLE;
          o.done = 1'b1;
        end
      end
      default: o.st.st = HIMS_TX_IDLE;
    endcase
    // A path change drops a packet in flight and restarts an unacknowledged message.
    if (sw) begin
      case (s.st)
        HIMS_TX_PKT: begin
          o.out = '0;
          o.drop = 1'b1;
          o.st.st = (acc && in.last) ? HIMS_TX_IDLE : HIMS_TX_FLUSH;
        end
        HIMS_TX_MSEND, HIMS_TX_MWAIT: begin
          if (!o.done) begin
            o.out = '0;
            o.st.idx = '0;
            o.st.pace = '0;
            o.st.st = HIMS_TX_MSEND;
          end
        end
        default: o.drop = 1'b0;
      endcase
    end
    return o;
  endfunction

  // Receiver step: forward beats, acknowledge a finished message, drop on a switch.
  function automatic hims_rxo_s hims_rx_step(logic busy, hims_beat_s in, logic sw);
    hims_rxo_s o;
    o = '0;
    o.busy = busy;
    if (sw) begin
      o.drop = busy;
      o.busy = 1'b0;
    end else if (in.valid) begin
      o.out = in;
      o.out.ack = 1'b0;
      o.out.hs = 1'b0;
      o.busy = !in.last;
      o.ack = in.msg && in.last;
    end
    return o;
  endfunction

endpackage

// *** logic/hims_if.sv ***
`timescale 1ns/1ps

// ****************************************************************************
// Link between the integrated MAC end and the PHY end
// ****************************************************************************
interface hims_if;
  // Link clock and the host link reset, both made by the MAC end.
  logic link_clk;
  logic host_link_reset_n;
  // Beats toward the PHY on each path.
  hims_pkg::hims_beat_s h2d_ser;
  hims_pkg::hims_beat_s h2d_smb;
  // Beats toward the MAC on each path.
  hims_pkg::hims_beat_s d2h_ser;
  hims_pkg::hims_beat_s d2h_smb;

  modport dev (
    input link_clk,
    input host_link_reset_n,
    input h2d_ser,
    input h2d_smb,
    output d2h_ser,
    output d2h_smb
  );

  modport host (
    output link_clk,
    output host_link_reset_n,
    output h2d_ser,
    output h2d_smb,
    input d2h_ser,
    input d2h_smb
  );
endinterface

// *** logic/hims_host.sv ***
`timescale 1ns/1ps
`include "hims_defines.svh"

// ****************************************************************************
// MAC end of the host interconnect: makes the link clock and host link reset
// ****************************************************************************
module hims_host (
  // Core clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  // Link toward the PHY.
  hims_if.host bus,
  // Platform power state and bus rate.
  input wire logic i_host_active,
  input wire hims_pkg::hims_smb_rate_e i_smb_rate,
  // Transmit toward the PHY.
  input wire hims_pkg::hims_beat_s i_tx,
  output logic o_tx_ready,
  output logic o_tx_drop,
  output logic o_msg_acked,
  // Receive from the PHY.
  output hims_pkg::hims_beat_s o_rx,
  output logic o_rx_drop,
  output logic o_switch_busy
);

  // ****************************************************************************
  // State
  // ****************************************************************************
  typedef struct packed {
    logic [`HIMS_LINK_CNT_W-1:0] cnt;
    logic [1:0] rst_h;
    logic lclk;
    logic hl_n;
    hims_pkg::hims_path_e path;
    logic hs_wait;
    hims_pkg::hims_tx_s tx;
    logic tx_rdy;
    logic rx_busy;
    hims_pkg::hims_beat_s ser_out;
    hims_pkg::hims_beat_s smb_out;
    hims_pkg::hims_beat_s rx;
    logic rx_drop;
    logic tx_drop;
    logic acked;
  } hims_host_s;

  hims_host_s q;
  hims_host_s d;

  // ****************************************************************************
  // Divider and link logic
  // ****************************************************************************
  // The link side moves only at the falling edge of the link clock it makes.
  always_comb begin
    hims_pkg::hims_txo_s txo;
    hims_pkg::hims_rxo_s rxo;
    hims_pkg::hims_beat_s in_beat;
    hims_pkg::hims_beat_s out_beat;
    logic tick;
    logic sw;
    logic [`HIMS_LINK_CNT_W-1:0] run_cnt;
    logic run_lclk;
    txo = '0;
    rxo = '0;
    in_beat = '0;
    out_beat = '0;
    sw = 1'b0;
    tick = 1'b0;
    run_cnt = '0;
    run_lclk = 1'b0;
    d = q;
    d.rst_h = {q.rst_h[0], i_reset};
    d.rx = '0;
    d.rx_drop = 1'b0;
    d.tx_drop = 1'b0;
    d.acked = 1'b0;
    tick = q.lclk && (q.cnt == `HIMS_LINK_CNT_W'(`HIMS_LINK_HALF - 1));
    if (q.cnt == `HIMS_LINK_CNT_W'(`HIMS_LINK_HALF - 1)) begin
      d.cnt = '0;
      d.lclk = !q.lclk;
    end else begin
      d.cnt = q.cnt + `HIMS_LINK_CNT_W'(1);
    end
    run_cnt = d.cnt;
    run_lclk = d.lclk;
    if (tick) begin
      // Host link reset follows the platform state.
      d.hl_n = i_host_active;
      sw = (i_host_active != q.hl_n);
      d.path = i_host_active ? hims_pkg::HIMS_PATH_SER : hims_pkg::HIMS_PATH_SMB;
      // New traffic, except a packet beat taken in the switch cycle itself, waits until the PHY confirms the switch on the bus.
      d.hs_wait = sw || (q.hs_wait && !bus.d2h_smb.hs);
      in_beat = (q.path == hims_pkg::HIMS_PATH_SER) ? bus.d2h_ser : bus.d2h_smb;
      txo = hims_pkg::hims_tx_step(q.tx, i_tx, i_tx.valid && q.tx_rdy, sw,
                                   bus.d2h_ser.ack || bus.d2h_smb.ack, !q.hs_wait && !sw,
                                   hims_pkg::hims_pace_len(d.path, i_smb_rate));
      rxo = hims_pkg::hims_rx_step(q.rx_busy, in_beat, sw);
      d.tx = txo.st;
      d.rx_busy = rxo.busy;
      d.rx = rxo.out;
      d.rx_drop = rxo.drop;
      d.tx_drop = txo.drop;
      d.acked = txo.done;
      out_beat = txo.out;
      out_beat.ack = rxo.ack;
      d.ser_out = (d.path == hims_pkg::HIMS_PATH_SER) ? out_beat : '0;
      d.smb_out = (d.path == hims_pkg::HIMS_PATH_SMB) ? out_beat : '0;
    end
    // Ready is raised only for a cycle in which a beat can be taken.
    d.tx_rdy = d.lclk && (d.cnt == `HIMS_LINK_CNT_W'(`HIMS_LINK_HALF - 1)) &&
               hims_pkg::hims_tx_rdy(d.tx, !d.hs_wait);
    // Reset pins the divider to a known phase for its first two edges only; after that the link clock runs on,
    // so the far end's reset synchroniser keeps being clocked while reset is held.
    if (i_reset) begin
      d = '0;
      d.rst_h = {q.rst_h[0], i_reset};
      if (q.rst_h == 2'h3) begin
        d.cnt = run_cnt;
        d.lclk = run_lclk;
      end
    end
  end

  // Registers the whole state.
  always_ff @(posedge i_clk) begin
    q <= d;
  end

  // ****************************************************************************
  // Outputs
  // ****************************************************************************
  // Every output is a state flip-flop.
  assign bus.link_clk = q.lclk;
  assign bus.host_link_reset_n = q.hl_n;
  assign bus.h2d_ser = q.ser_out;
  assign bus.h2d_smb = q.smb_out;
  assign o_tx_ready = q.tx_rdy;
  assign o_tx_drop = q.tx_drop;
  assign o_msg_acked = q.acked;
  assign o_rx = q.rx;
  assign o_rx_drop = q.rx_drop;
  assign o_switch_busy = q.hs_wait;

endmodule

// *** dv/hims_chk.sv ***
`timescale 1ns/1ps

// ****
// Link checker
// ****
module hims_chk (
  // Link signals.
  input wire logic link_clk,
  input wire logic i_reset,
  input wire logic host_link_reset_n,
  input wire hims_pkg::hims_beat_s h2d_ser,
  input wire hims_pkg::hims_beat_s h2d_smb,
  input wire hims_pkg::hims_beat_s d2h_ser,
  input wire hims_pkg::hims_beat_s d2h_smb
);
  // All checks run on the link clock.
  default clocking @(posedge link_clk); endclocking
  default disable iff (i_reset);

  // A path change, and the final byte of a serial path message in each direction.
  sequence s_sw;
    $changed(host_link_reset_n);
  endsequence
  sequence s_dn_end;
    h2d_ser.valid && h2d_ser.msg && h2d_ser.last;
  endsequence
  sequence s_up_end;
    d2h_ser.valid && d2h_ser.msg && d2h_ser.last;
  endsequence

  property p_hs;
    s_sw |-> ##[2:6] d2h_smb.hs;
  endproperty
  property p_hs1;
    d2h_smb.hs |=> !d2h_smb.hs;
  endproperty
  property p_serq;
    !host_link_reset_n && !$past(host_link_reset_n, 6) |-> !d2h_ser.valid && !h2d_ser.valid;
  endproperty
  property p_smbq;
    host_link_reset_n && $past(host_link_reset_n, 6) |-> !d2h_smb.valid && !h2d_smb.valid;
  endproperty
  property p_dpace;
    d2h_smb.valid |=> !d2h_smb.valid [*8];
  endproperty
  property p_hpace;
    h2d_smb.valid |=> !h2d_smb.valid [*8];
  endproperty
  property p_hsp;
    !(d2h_ser.hs || h2d_ser.hs || h2d_smb.hs);
  endproperty
  property p_dack;
    s_dn_end |-> ##[1:3] (d2h_ser.ack || d2h_smb.ack);
  endproperty
  property p_uack;
    s_up_end |-> ##[0:2] (h2d_ser.ack || h2d_smb.ack);
  endproperty

  a_hs: assert property (p_hs) else $error("no handshake after path change");
  a_hs1: assert property (p_hs1) else $error("handshake longer than one cycle");
  a_serq: assert property (p_serq) else $error("serial beat while bus path selected");
  a_smbq: assert property (p_smbq) else $error("bus beat while serial path selected");
  a_dpace: assert property (p_dpace) else $error("device bus beats too close");
  a_hpace: assert property (p_hpace) else $error("host bus beats too close");
  a_hsp: assert property (p_hsp) else $error("handshake on wrong lane");
  a_dack: assert property (p_dack) else $error("device did not acknowledge message");
  a_uack: assert property (p_uack) else $error("host did not acknowledge message");
endmodule

// *** dv/hims_bench.sv ***
`timescale 1ns/1ps

// ****
// Bench for the host interconnect mode switch
// ****
module hims_bench;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic act = 1'b0;
  logic [3:0] cause = 4'h0;
  logic [5:0] seen = 6'h00;
  logic [7:0] lastd = 8'h00;
  hims_pkg::hims_smb_rate_e rate = hims_pkg::HIMS_SMB_PLUS;
  hims_pkg::hims_beat_s h_tx = '0;
  hims_pkg::hims_beat_s d_tx = '0;
  hims_pkg::hims_beat_s h_rx;
  hims_pkg::hims_beat_s d_rx;
  logic h_rdy, h_drop, h_ack, h_rxdrop, h_busy;
  logic d_rdy, d_drop, d_ack, d_rxdrop, d_stray, smb, pdn, spd10, ei;
  logic stray = 1'b0;
  int error_cnt = 0;
  int compares = 0;
  int gap = 0;
  int lcnt = 0;
  int rxn = 0;
  int rn;
  // Rows: active, four idle causes, expected bus path, expected idle.
  logic [6:0] rows [7] = '{7'h02, 7'h40, 7'h61, 7'h51, 7'h49, 7'h45, 7'h02};
  // Bus byte time of nine bits, in 32 ns link cycles, per rate.
  int nb [3] = '{32'h0afd, 32'h02c0, 32'h011a};

  hims_if hims_if_i ();
  hims_host hims_host_i (.i_clk(i_clk), .i_reset(i_reset), .bus(hims_if_i.host), .i_host_active(act),
    .i_smb_rate(rate), .i_tx(h_tx), .o_tx_ready(h_rdy), .o_tx_drop(h_drop), .o_msg_acked(h_ack),
    .o_rx(h_rx), .o_rx_drop(h_rxdrop), .o_switch_busy(h_busy));
  hims_device hims_device_i (.i_clk(i_clk), .i_reset(i_reset), .bus(hims_if_i.dev),
    .i_phy_power_down(cause[3]), .i_phy_idle(cause[2]), .i_link_disconnect(cause[1]),
    .i_low_power_idle(cause[0]), .i_smb_rate(rate), .i_tx(d_tx), .o_tx_ready(d_rdy), .o_tx_drop(d_drop),
    .o_msg_acked(d_ack), .o_rx(d_rx), .o_rx_drop(d_rxdrop), .o_stray_beat(d_stray), .o_smbus_active(smb),
    .o_serial_power_down(pdn), .o_speed_10(spd10), .o_serial_electrical_idle(ei));
  hims_chk hims_chk_i (.link_clk(hims_if_i.link_clk), .i_reset(i_reset),
    .host_link_reset_n(hims_if_i.host_link_reset_n), .h2d_ser(hims_if_i.h2d_ser),
    .h2d_smb(hims_if_i.h2d_smb), .d2h_ser(hims_if_i.d2h_ser), .d2h_smb(hims_if_i.d2h_smb));

  // Core clock.
  always #4 i_clk = ~i_clk;

  // Device side pulses and the spacing of received beats, in link cycles.
  always @(negedge hims_if_i.link_clk) begin
    lcnt++;
    if (d_rx.valid === 1'b1) begin
      gap = lcnt;
      lcnt = 0;
      rxn++;
      lastd = d_rx.data;
    end
    if (d_rxdrop === 1'b1) seen[0] = 1'b1;
    if (d_ack === 1'b1) seen[1] = 1'b1;
    if (d_drop === 1'b1) seen[4] = 1'b1;
    if (d_stray === 1'b1) stray = 1'b1;
  end

  // Host side pulses.
  always @(negedge i_clk) begin
    if (h_drop === 1'b1) seen[2] = 1'b1;
    if (h_ack === 1'b1) seen[3] = 1'b1;
    if (h_rxdrop === 1'b1) seen[5] = 1'b1;
  end

  task automatic report_and_stop();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask

  // Waits one falling edge of the clock of the chosen end.
  task automatic step(input logic side);
    if (side) @(negedge hims_if_i.link_clk);
    else @(negedge i_clk);
  endtask

  // Offers one beat and holds it until the ready edge takes it.
  task automatic send(input logic side, input logic [7:0] d, input logic l, input logic m);
    int k;
    k = 0;
    step(side);
    if (side) d_tx = {1'b1, l, m, 2'h0, d};
    else h_tx = {1'b1, l, m, 2'h0, d};
    while ((side ? d_rdy : h_rdy) !== 1'b1 && k < 20000) begin
      step(side);
      k++;
    end
    if (k == 20000) begin
      error_cnt++;
      report_and_stop();
    end
    step(side);
    if (side) d_tx = '0;
    else h_tx = '0;
  endtask

  // Lets a path change finish.
  task automatic settle();
    int k;
    k = 0;
    repeat (200) @(negedge i_clk);
    while (h_busy !== 1'b0 && k < 1000) begin
      @(negedge i_clk);
      k++;
    end
    if (k == 1000) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    repeat (12) @(negedge i_clk);
    i_reset = 1'b0;
    repeat (20) @(negedge i_clk);
    foreach (rows[i]) begin
      act = rows[i][6];
      cause = rows[i][5:2];
      settle();
      chk(smb, rows[i][1]);
      chk(pdn, rows[i][1]);
      chk(spd10, rows[i][1]);
      chk(ei, rows[i][0]);
    end
    for (int r = 0; r < 3; r++) begin
      rate = hims_pkg::hims_smb_rate_e'(r);
      send(1'b0, 8'ha0, 1'b0, 1'b0);
      send(1'b0, 8'ha1, 1'b1, 1'b0);
      settle();
      chk(32'(gap >= nb[r] && gap <= nb[r] + 8), 32'h1);
    end
    seen = 6'h00;
    send(1'b0, 8'h5a, 1'b0, 1'b1);
    send(1'b0, 8'h5b, 1'b1, 1'b1);
    // Switch only once the first message byte has gone out on the bus, so it is really resent.
    rn = 0;
    while (hims_if_i.h2d_smb.valid !== 1'b1 && rn < 4000) begin
      @(negedge i_clk);
      rn++;
    end
    chk(32'(rn < 4000), 32'h1);
    act = 1'b1;
    settle();
    chk(seen[3], 1'b1);
    chk(lastd, 8'h5b);
    send(1'b1, 8'h33, 1'b1, 1'b1);
    settle();
    chk(seen[1], 1'b1);
    seen = 6'h00;
    rn = rxn;
    send(1'b0, 8'h11, 1'b0, 1'b0);
    act = 1'b0;
    send(1'b0, 8'h12, 1'b1, 1'b0);
    settle();
    chk(seen[2], 1'b1);
    chk(seen[0], 1'b1);
    chk(rxn, rn + 1);
    send(1'b1, 8'h21, 1'b0, 1'b0);
    act = 1'b1;
    send(1'b1, 8'h22, 1'b1, 1'b0);
    settle();
    chk(seen[4], 1'b1);
    chk(seen[5], 1'b1);
    chk(stray, 1'b0);
    report_and_stop();
  end
endmodule
